/* File: logic/quadrature_position_velocity.sv */
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none

module quadrature_position_velocity (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        encoder_channel_first,
    input  wire logic        encoder_channel_second,
    input  wire logic        encoder_index,
    output logic             irq_o
);

    // ========================================================================
    // State
    typedef struct packed {
        logic [8:0]  ctrl;
        logic [31:0] pos;
        logic [31:0] limit;
        logic [31:0] period;
        logic [31:0] timer;
        logic [31:0] vel;
        logic [31:0] accum;
        logic [6:0]  pre;
        logic [3:0]  mask;
        logic [3:0]  raw;
        logic        a_prev;
        logic        b_prev;
        logic        idx_prev;
        logic        dir_rev;
        logic        ack;
        logic        irq;
        logic [31:0] rdat;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wdat[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [31:0] pos_step(input logic [31:0] pos,
                                             input logic [31:0] lim,
                                             input logic        rev);
        if (rev) begin
            return (pos == 32'h0000_0000) ? lim : pos - 32'h0000_0001;
        end
        return (pos >= lim) ? 32'h0000_0000 : pos + 32'h0000_0001;
    endfunction : pos_step

    // ========================================================================
    // Input synchronisation
    logic [2:0] pins_s;

    pin_sync #(
        .W   (3)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     ({encoder_index, encoder_channel_second, encoder_channel_first}),
        .sync    (pins_s)
    );

    // ========================================================================
    // Decoding
    logic        en;
    logic        phase;
    logic        a_in;
    logic        b_in;
    logic        a_old;
    logic        b_old;
    logic        idx_in;
    logic        a_chg;
    logic        b_chg;
    logic        both_chg;
    logic        step;
    logic        step_rev;
    logic        idx_rise;
    logic        idx_load;
    logic        dir_chg;
    logic        vel_on;
    logic [6:0]  div_mask;
    logic        emit;
    logic        expire;
    logic [3:0]  events;

    assign en       = s_q.ctrl[qpv_pkg::CTRL_EN];
    assign phase    = !s_q.ctrl[qpv_pkg::CTRL_STEPDIR];
    assign a_in     = s_q.ctrl[qpv_pkg::CTRL_SWAP] ? pins_s[1] : pins_s[0];
    assign b_in     = s_q.ctrl[qpv_pkg::CTRL_SWAP] ? pins_s[0] : pins_s[1];
    assign idx_in   = pins_s[2];
    // History holds the pins unswapped, so flipping the swap bit is never an edge
    assign a_old    = s_q.ctrl[qpv_pkg::CTRL_SWAP] ? s_q.b_prev : s_q.a_prev;
    assign b_old    = s_q.ctrl[qpv_pkg::CTRL_SWAP] ? s_q.a_prev : s_q.b_prev;
    assign a_chg    = a_in ^ a_old;
    assign b_chg    = b_in ^ b_old;
    assign both_chg = en & phase & a_chg & b_chg;
    // A double change carries no direction, so quadrature mode never counts it
    assign step     = phase
                    ? en & !both_chg & (a_chg | (s_q.ctrl[qpv_pkg::CTRL_BOTH] & b_chg))
                    : en & a_in & !a_old;
    // Forward when the first channel leads the second, or the second leads the first with the swap bit set
    assign step_rev = phase ? (a_chg ? (a_in == b_in) : (a_in != b_in))
                            : b_in;
    assign idx_rise = en & idx_in & !s_q.idx_prev;
    assign idx_load = idx_rise & s_q.ctrl[qpv_pkg::CTRL_IDXRST];
    assign dir_chg  = step & (step_rev != s_q.dir_rev);
    assign vel_on   = en & s_q.ctrl[qpv_pkg::CTRL_VELEN];
    assign div_mask = 7'((8'h01 << s_q.ctrl[qpv_pkg::CTRL_DIV_LSB +: qpv_pkg::DIV_W]) - 8'h01);
    assign emit     = vel_on & step & ((s_q.pre & div_mask) == div_mask);
    assign expire   = vel_on & (s_q.period != 32'h0000_0000)
                    & (s_q.timer == 32'h0000_0000);

    always_comb begin
        events = 4'h0;
        events[qpv_pkg::EV_INDEX] = idx_rise;
        events[qpv_pkg::EV_TIMER] = expire;
        events[qpv_pkg::EV_DIR]   = dir_chg;
        events[qpv_pkg::EV_ERROR] = both_chg;
    end

    // ========================================================================
    // Bus decode
    logic        req;
    logic        wr_take;
    logic [3:0]  clr_bits;
    logic [31:0] rd_mux;

    assign req      = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master sees ack
    assign wr_take  = req & wb_we_i & s_q.ack;
    assign clr_bits = (wr_take && wb_adr_i == qpv_pkg::OFF_INT_MSKD && wb_sel_i[0])
                    ? wb_dat_i[3:0] : 4'h0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            qpv_pkg::OFF_CTRL:     rd_mux = {23'h000000, s_q.ctrl};
            qpv_pkg::OFF_STATUS:   rd_mux = {30'h00000000, s_q.dir_rev,
                                             s_q.raw[qpv_pkg::EV_ERROR]};
            qpv_pkg::OFF_POSITION: rd_mux = s_q.pos;
            qpv_pkg::OFF_LIMIT:    rd_mux = s_q.limit;
            qpv_pkg::OFF_PERIOD:   rd_mux = s_q.period;
            qpv_pkg::OFF_TIMER:    rd_mux = s_q.timer;
            qpv_pkg::OFF_VELOCITY: rd_mux = s_q.vel;
            qpv_pkg::OFF_RUNNING:  rd_mux = s_q.accum;
            qpv_pkg::OFF_INT_MASK: rd_mux = {28'h0000000, s_q.mask};
            qpv_pkg::OFF_INT_RAW:  rd_mux = {28'h0000000, s_q.raw};
            qpv_pkg::OFF_INT_MSKD: rd_mux = {28'h0000000, s_q.raw & s_q.mask};
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // ========================================================================
    // Next state
    always_comb begin
        s_d = s_q;

        s_d.ack  = req & !s_q.ack;
        s_d.rdat = (req & !s_q.ack) ? rd_mux : 32'h0000_0000;

        if (wr_take) begin
            case (wb_adr_i)
                qpv_pkg::OFF_CTRL:     s_d.ctrl   = 9'(merge({23'h000000, s_q.ctrl},
                                                             wb_dat_i, wb_sel_i));
                qpv_pkg::OFF_LIMIT:    s_d.limit  = merge(s_q.limit, wb_dat_i, wb_sel_i);
                qpv_pkg::OFF_PERIOD:   s_d.period = merge(s_q.period, wb_dat_i, wb_sel_i);
                qpv_pkg::OFF_INT_MASK: s_d.mask   = wb_sel_i[0] ? wb_dat_i[3:0] : s_q.mask;
                default:               s_d.ctrl   = s_q.ctrl;
            endcase
        end

        // Edge history tracks even while disabled, so enabling adds no edge
        s_d.a_prev   = pins_s[0];
        s_d.b_prev   = pins_s[1];
        s_d.idx_prev = idx_in;

        if (step) begin
            s_d.dir_rev = step_rev;
        end

        if (wr_take && wb_adr_i == qpv_pkg::OFF_POSITION) begin
            s_d.pos = merge(s_q.pos, wb_dat_i, wb_sel_i);
        end else if (idx_load) begin
            s_d.pos = step_rev & step | (!step & s_q.dir_rev)
                    ? s_q.limit
                    : 32'h0000_0000;
        end else if (step) begin
            s_d.pos = pos_step(s_q.pos, s_q.limit, step_rev);
        end

        if (!vel_on) begin
            s_d.pre   = 7'h00;
            s_d.accum = 32'h0000_0000;
            s_d.timer = (s_q.period == 32'h0000_0000) ? 32'h0000_0000
                                                      : s_q.period - 32'h0000_0001;
        end else begin
            if (step) begin
                s_d.pre = s_q.pre + 7'h01;
            end
            if (expire) begin
                s_d.vel   = s_q.accum + {31'h00000000, emit};
                s_d.accum = 32'h0000_0000;
                s_d.timer = s_q.period - 32'h0000_0001;
            end else begin
                s_d.accum = s_q.accum + {31'h00000000, emit};
                s_d.timer = (s_q.timer == 32'h0000_0000) ? 32'h0000_0000
                                                         : s_q.timer - 32'h0000_0001;
            end
        end

        // A new event in the clearing cycle wins over the clear
        s_d.raw = (s_q.raw & ~clr_bits) | events;
        s_d.irq = |(s_q.raw & s_q.mask);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q        <= '0;
            s_q.ctrl   <= qpv_pkg::CTRL_RST;
            s_q.pos    <= qpv_pkg::POS_RST;
            s_q.limit  <= qpv_pkg::LIMIT_RST;
            s_q.period <= qpv_pkg::PERIOD_RST;
            s_q.mask   <= qpv_pkg::MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign irq_o    = s_q.irq;

    // ========================================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    idx_zero_a: assert property (idx_load && !step && !s_q.dir_rev && !wr_take
        |=> s_q.pos == 32'h0000_0000)
        else $error("forward index did not clear position");

    idx_limit_a: assert property (idx_load && !step && s_q.dir_rev && !wr_take
        |=> s_q.pos == $past(s_q.limit))
        else $error("reverse index did not load the limit");

    idx_ignored_a: assert property (idx_rise && !idx_load && !step && !wr_take
        |=> $stable(s_q.pos))
        else $error("index moved position with index reset off");

    phase_err_a: assert property (both_chg |=> s_q.raw[qpv_pkg::EV_ERROR] ##1
        (s_q.raw[qpv_pkg::EV_ERROR] || $past(clr_bits[qpv_pkg::EV_ERROR])))
        else $error("phase error flag not set");

    irq_gate_a: assert property (##1 irq_o == $past(|(s_q.raw & s_q.mask))
        || $past(rst))
        else $error("interrupt line disagrees with masked flags");

    clear_keep_a: assert property (s_q.raw[qpv_pkg::EV_TIMER]
        && !clr_bits[qpv_pkg::EV_TIMER] |=> s_q.raw[qpv_pkg::EV_TIMER])
        else $error("unnamed flag lost on clear");

    vel_latch_a: assert property (expire
        |=> s_q.vel == $past(s_q.accum) + {31'h00000000, $past(emit)}
            && s_q.accum == 32'h0000_0000)
        else $error("velocity not latched and cleared at period end");

    vel_idle_a: assert property (!vel_on |=> s_q.accum == 32'h0000_0000
        && s_q.pre == 7'h00)
        else $error("velocity running while disabled");

    dir_hold_a: assert property (!step |=> $stable(s_q.dir_rev))
        else $error("direction changed without a step");

    raw_set_a: assert property (idx_rise |=> s_q.raw[qpv_pkg::EV_INDEX])
        else $error("index flag not set on event");

    pos_load_a: assert property (wr_take && wb_adr_i == qpv_pkg::OFF_POSITION
        && wb_sel_i == 4'hF |=> s_q.pos == $past(wb_dat_i))
        else $error("position write did not load the counter");

    idle_hold_a: assert property (!en && !wr_take |=> $stable(s_q.pos)
        && $stable(s_q.raw))
        else $error("disabled unit changed position or flags");

    mask_gate_a: assert property ((s_q.raw & s_q.mask) == 4'h0 |=> !irq_o)
        else $error("masked flags raised the interrupt");

    clr_named_a: assert property (clr_bits[qpv_pkg::EV_INDEX] && !idx_rise
        |=> !s_q.raw[qpv_pkg::EV_INDEX])
        else $error("named flag survived its clear");

    timer_load_a: assert property (expire
        |=> s_q.timer == $past(s_q.period) - 32'h0000_0001)
        else $error("timer not reloaded at period end");

    no_pin_edge_a: assert property ($stable(pins_s[1:0]) |-> !a_chg && !b_chg)
        else $error("channel edge seen without a pin change");

endmodule : quadrature_position_velocity

`default_nettype wire

/* File: logic/qpv_pkg.sv */
package qpv_pkg;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_POSITION  = 8'h08;
    localparam logic [7:0]  OFF_LIMIT     = 8'h0C;
    localparam logic [7:0]  OFF_PERIOD    = 8'h10;
    localparam logic [7:0]  OFF_TIMER     = 8'h14;
    localparam logic [7:0]  OFF_VELOCITY  = 8'h18;
    localparam logic [7:0]  OFF_RUNNING   = 8'h1C;
    localparam logic [7:0]  OFF_INT_MASK  = 8'h20;
    localparam logic [7:0]  OFF_INT_RAW   = 8'h24;
    localparam logic [7:0]  OFF_INT_MSKD  = 8'h28;

    // ========================================================================
    // Control fields
    localparam int          CTRL_W        = 9;
    localparam int          CTRL_EN       = 0;
    localparam int          CTRL_BOTH     = 1;
    localparam int          CTRL_IDXRST   = 2;
    localparam int          CTRL_STEPDIR  = 3;
    localparam int          CTRL_SWAP     = 4;
    localparam int          CTRL_VELEN    = 5;
    localparam int          CTRL_DIV_LSB  = 6;
    localparam int          DIV_W         = 3;
    localparam int          PRE_W         = 7;

    // ========================================================================
    // Status and event fields
    localparam int          STAT_ERR      = 0;
    localparam int          STAT_REV      = 1;
    localparam int          EV_W          = 4;
    localparam int          EV_INDEX      = 0;
    localparam int          EV_TIMER      = 1;
    localparam int          EV_DIR        = 2;
    localparam int          EV_ERROR      = 3;

    // ========================================================================
    // Reset values
    localparam logic [8:0]  CTRL_RST      = 9'h000;
    localparam logic [31:0] POS_RST       = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RST     = 32'hFFFF_FFFF;
    localparam logic [31:0] PERIOD_RST    = 32'h0000_0000;
    localparam logic [3:0]  MASK_RST      = 4'h0;

endpackage : qpv_pkg

/* File: logic/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    assign sync = sync_q;

endmodule : pin_sync

`default_nettype wire

/* File: verification/encoder_model.sv */
`timescale 1ns/1ns
`default_nettype none

module encoder_model (
    input  wire logic clk_sys,
    output logic      chan_first,
    output logic      chan_second,
    output logic      index_pin
);
    // ========================================================================
    // Pin drive
    initial begin
        chan_first  = 1'b0;
        chan_second = 1'b0;
        index_pin   = 1'b0;
    end

    // Every level is held four clocks so the synchroniser sees each change alone
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask : settle

    // Quarter steps; forward means the first channel leads the second
    task automatic turn(input logic rev, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if ((chan_first == chan_second) ^ rev) begin
                chan_first <= ~chan_first;
            end else begin
                chan_second <= ~chan_second;
            end
            settle();
        end
    endtask : turn

    // Both channels toggle in one sample, which a real encoder never does
    task automatic flip_both();
        @(posedge clk_sys);
        chan_first  <= ~chan_first;
        chan_second <= ~chan_second;
        settle();
    endtask : flip_both

    // Clock pulses on the first channel, direction level on the second
    task automatic step_pulse(input logic rev, input int n);
        @(posedge clk_sys);
        chan_second <= rev;
        chan_first  <= 1'b0;
        settle();
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            chan_first <= 1'b1;
            settle();
            @(posedge clk_sys);
            chan_first <= 1'b0;
            settle();
        end
    endtask : step_pulse

    task automatic index_pulse();
        @(posedge clk_sys);
        index_pin <= 1'b1;
        settle();
        @(posedge clk_sys);
        index_pin <= 1'b0;
        settle();
    endtask : index_pulse
endmodule : encoder_model

`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top;
    localparam logic [31:0] EN   = 32'h1 << qpv_pkg::CTRL_EN;
    localparam logic [31:0] BOTH = 32'h1 << qpv_pkg::CTRL_BOTH;
    localparam logic [31:0] IDX  = 32'h1 << qpv_pkg::CTRL_IDXRST;
    localparam logic [31:0] SD   = 32'h1 << qpv_pkg::CTRL_STEPDIR;
    localparam logic [31:0] SW   = 32'h1 << qpv_pkg::CTRL_SWAP;
    localparam logic [31:0] VEL  = 32'h1 << qpv_pkg::CTRL_VELEN;

    logic        clk_sys;
    logic        rst;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        ch_first;
    logic        ch_second;
    logic        ch_index;
    logic        irq_o;
    logic [31:0] v;
    int          bad_count = 0;
    int          n_checks = 0;

    quadrature_position_velocity u_dut (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .encoder_channel_first(ch_first), .encoder_channel_second(ch_second),
        .encoder_index(ch_index), .irq_o(irq_o));

    encoder_model u_enc (.clk_sys(clk_sys), .chan_first(ch_first),
        .chan_second(ch_second), .index_pin(ch_index));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // ========================================================================
    // Bus cycles
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [31:0] wd, output logic [31:0] rdv);
        int k;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        for (k = 0; k < 16; k++) begin
            @(posedge clk_sys);
            if (wb_ack_o === 1'b1) break;
        end
        rdv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (k == 16) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wb_xfer

    task automatic wb_wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] x;
        wb_xfer(1'b1, adr, 4'hF, d, x);
    endtask : wb_wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
        wb_xfer(1'b0, adr, 4'hF, 32'h0, v);
        `CHK(v, e)
    endtask : rd_chk

    // Polls the raw flags; a flag that never comes ends the run as a failure
    task automatic wait_bit(input int b);
        for (int i = 0; i < 200; i++) begin
            wb_xfer(1'b0, qpv_pkg::OFF_INT_RAW, 4'hF, 32'h0, v);
            if (v[b] === 1'b1) return;
        end
        bad_count++;
        tally_and_finish();
    endtask : wait_bit

    // ========================================================================
    // Scenarios
    task automatic t_reset();
        rd_chk(qpv_pkg::OFF_CTRL, 32'h0);
        rd_chk(qpv_pkg::OFF_STATUS, 32'h0);
        rd_chk(qpv_pkg::OFF_POSITION, qpv_pkg::POS_RST);
        rd_chk(qpv_pkg::OFF_LIMIT, qpv_pkg::LIMIT_RST);
        rd_chk(qpv_pkg::OFF_PERIOD, qpv_pkg::PERIOD_RST);
        rd_chk(qpv_pkg::OFF_INT_MASK, 32'h0);
        rd_chk(qpv_pkg::OFF_INT_RAW, 32'h0);
        wb_wr(8'h30, 32'h5A5A_5A5A);
        rd_chk(8'h30, 32'h0);
        wb_xfer(1'b1, qpv_pkg::OFF_LIMIT, 4'h1, 32'h0000_0012, v);
        rd_chk(qpv_pkg::OFF_LIMIT, 32'hFFFF_FF12);
    endtask : t_reset

    task automatic t_phase();
        wb_wr(qpv_pkg::OFF_CTRL, EN | BOTH);
        u_enc.turn(1'b0, 4);
        rd_chk(qpv_pkg::OFF_POSITION, 32'h4);
        rd_chk(qpv_pkg::OFF_STATUS, 32'h0);
        u_enc.turn(1'b1, 1);
        rd_chk(qpv_pkg::OFF_POSITION, 32'h3);
        rd_chk(qpv_pkg::OFF_INT_RAW, 32'h4);
        repeat (20) @(posedge clk_sys);
        rd_chk(qpv_pkg::OFF_STATUS, 32'h2);
        wb_wr(qpv_pkg::OFF_CTRL, EN);
        u_enc.turn(1'b0, 4);
        rd_chk(qpv_pkg::OFF_POSITION, 32'h5);
    endtask : t_phase

    task automatic t_swap_step();
        wb_wr(qpv_pkg::OFF_CTRL, EN | BOTH | SW);
        wb_wr(qpv_pkg::OFF_POSITION, 32'h64);
        u_enc.turn(1'b0, 3);
        rd_chk(qpv_pkg::OFF_POSITION, 32'h61);
        rd_chk(qpv_pkg::OFF_STATUS, 32'h2);
        wb_wr(qpv_pkg::OFF_CTRL, EN | SD);
        wb_wr(qpv_pkg::OFF_POSITION, 32'h10);
        u_enc.step_pulse(1'b0, 3);
        rd_chk(qpv_pkg::OFF_POSITION, 32'h13);
        u_enc.step_pulse(1'b1, 2);
        rd_chk(qpv_pkg::OFF_POSITION, 32'h11);
    endtask : t_swap_step

    task automatic t_index();
        wb_wr(qpv_pkg::OFF_CTRL, 32'h0);
        wb_wr(qpv_pkg::OFF_LIMIT, 32'h3F);
        wb_wr(qpv_pkg::OFF_CTRL, EN | BOTH | IDX);
        wb_wr(qpv_pkg::OFF_POSITION, 32'hA);
        u_enc.turn(1'b0, 1);
        u_enc.index_pulse();
        rd_chk(qpv_pkg::OFF_POSITION, 32'h0);
        u_enc.turn(1'b1, 2);
        rd_chk(qpv_pkg::OFF_POSITION, 32'h3E);
        u_enc.index_pulse();
        rd_chk(qpv_pkg::OFF_POSITION, 32'h3F);
        u_enc.turn(1'b0, 1);
        rd_chk(qpv_pkg::OFF_POSITION, 32'h0);
        wb_wr(qpv_pkg::OFF_CTRL, EN | BOTH);
        wb_wr(qpv_pkg::OFF_POSITION, 32'h5);
        u_enc.index_pulse();
        rd_chk(qpv_pkg::OFF_POSITION, 32'h5);
    endtask : t_index

    task automatic t_error_irq();
        wb_wr(qpv_pkg::OFF_INT_MSKD, 32'hF);
        rd_chk(qpv_pkg::OFF_INT_RAW, 32'h0);
        u_enc.index_pulse();
        rd_chk(qpv_pkg::OFF_INT_RAW, 32'h1);
        `CHK(irq_o, 1'b0)
        wb_wr(qpv_pkg::OFF_INT_MASK, 32'h1);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_o, 1'b1)
        u_enc.flip_both();
        rd_chk(qpv_pkg::OFF_POSITION, 32'h5);
        rd_chk(qpv_pkg::OFF_STATUS, 32'h1);
        rd_chk(qpv_pkg::OFF_INT_RAW, 32'h9);
        rd_chk(qpv_pkg::OFF_INT_MSKD, 32'h1);
        wb_wr(qpv_pkg::OFF_INT_MSKD, 32'h1);
        rd_chk(qpv_pkg::OFF_INT_RAW, 32'h8);
        `CHK(irq_o, 1'b0)
        wb_wr(qpv_pkg::OFF_INT_MASK, 32'h8);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_o, 1'b1)
        rd_chk(qpv_pkg::OFF_INT_MSKD, 32'h8);
    endtask : t_error_irq

    task automatic t_velocity();
        wb_wr(qpv_pkg::OFF_CTRL, 32'h0);
        wb_wr(qpv_pkg::OFF_PERIOD, 32'h12C);
        wb_wr(qpv_pkg::OFF_CTRL, EN | BOTH | VEL);
        wait_bit(qpv_pkg::EV_TIMER);
        wb_wr(qpv_pkg::OFF_INT_MSKD, 32'h2);
        u_enc.turn(1'b0, 6);
        rd_chk(qpv_pkg::OFF_RUNNING, 32'h6);
        wait_bit(qpv_pkg::EV_TIMER);
        rd_chk(qpv_pkg::OFF_VELOCITY, 32'h6);
        rd_chk(qpv_pkg::OFF_RUNNING, 32'h0);
        wb_wr(qpv_pkg::OFF_CTRL, 32'h0);
        wb_wr(qpv_pkg::OFF_CTRL, EN | BOTH | VEL | (32'h7 << qpv_pkg::CTRL_DIV_LSB));
        u_enc.turn(1'b0, 8);
        rd_chk(qpv_pkg::OFF_RUNNING, 32'h0);
    endtask : t_velocity

    task automatic t_disable();
        logic [31:0] p;
        wb_wr(qpv_pkg::OFF_CTRL, VEL);
        wb_wr(qpv_pkg::OFF_INT_MSKD, 32'hF);
        wb_xfer(1'b0, qpv_pkg::OFF_POSITION, 4'hF, 32'h0, p);
        u_enc.turn(1'b0, 4);
        u_enc.index_pulse();
        repeat (350) @(posedge clk_sys);
        rd_chk(qpv_pkg::OFF_POSITION, p);
        rd_chk(qpv_pkg::OFF_INT_RAW, 32'h0);
        rd_chk(qpv_pkg::OFF_RUNNING, 32'h0);
        rd_chk(qpv_pkg::OFF_TIMER, 32'h12B);
    endtask : t_disable

    initial begin
        rst      = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_phase();
        t_swap_step();
        t_index();
        t_error_irq();
        t_velocity();
        t_disable();
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
